// ==== logic/msel_defines.vh ====
// Register offsets, field positions, reset values and timing counts for the media select block
`ifndef MSEL_DEFINES_VH
`define MSEL_DEFINES_VH

// Word indices; byte address is index times 16 plus port times 4
`define MSEL_IDX_CTRL        8'h17
`define MSEL_IDX_MEDIA_STAT  8'h20
`define MSEL_IDX_PD_CTRL     8'h23
`define MSEL_IDX_INT_STAT    8'h26
`define MSEL_IDX_AN_CTRL     8'h00
`define MSEL_IDX_LINK_STAT   8'h01
`define MSEL_IDX_RING_CTRL   8'h30

// Field positions
`define MSEL_BIT_SERDES_PREF 11
`define MSEL_BIT_MODE_LO     8
`define MSEL_BIT_MEDIA_LO    6
`define MSEL_BIT_PD_EN       10
`define MSEL_BIT_PD_RES_LO   8
`define MSEL_BIT_PD_INT      9
`define MSEL_BIT_AN_EN       12
`define MSEL_BIT_LINK        2
`define MSEL_BIT_RING_SWAP   0
`define MSEL_BIT_RING_MASTER 1
`define MSEL_BIT_STRAP       4

// Media chosen
`define MSEL_MEDIA_NONE      2'b00
`define MSEL_MEDIA_COPPER    2'b01
`define MSEL_MEDIA_SERDES    2'b10

// SerDes media modes
`define MSEL_MODE_1000X      2'b00
`define MSEL_MODE_100FX      2'b01
`define MSEL_MODE_SGMII      2'b10

// Detection results
`define MSEL_PD_SEARCH       2'b00
`define MSEL_PD_FOUND        2'b01
`define MSEL_PD_NONE         2'b10

// Reset values
`define MSEL_RST_CTRL        16'h0000
`define MSEL_RST_AN_EN       1'b1

// Detection window in microseconds and in clock cycles
`define MSEL_PD_TIME_US      5000
`define MSEL_CLK_MHZ         25
`define MSEL_PD_CYCLES       (`MSEL_PD_TIME_US * `MSEL_CLK_MHZ)

`define MSEL_NPORTS          4
`endif

// ==== logic/msel_port.v ====
// One port of media selection, powered-device detection and timing swap
`timescale 1ns/1ps
`include "msel_defines.vh"
module msel_port #(
  parameter PD_CYCLES = `MSEL_PD_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        serdes_pref_i,
  input  wire        pd_en_i,
  input  wire        an_en_i,
  input  wire        ring_swap_i,
  input  wire        ring_master_i,
  input  wire        int_rd_i,
  input  wire        cu_link_i,
  input  wire        cu_try_i,
  input  wire        sd_link_i,
  input  wire        flp_loop_i,
  input  wire        rx_lock_i,
  output reg  [1:0]  media_o,
  output wire        cu_allow_o,
  output reg  [1:0]  pd_res_o,
  output reg         pd_int_o,
  output wire        pd_flp_tx_o,
  output wire        an_run_o,
  output wire        link_up_o,
  output reg         use_rcv_clk_o,
  output reg         freeze_rec_o
);

  localparam ST_OFF  = 2'd0;
  localparam ST_SRCH = 2'd1;
  localparam ST_AN   = 2'd2;
  localparam ST_HOLD = 2'd3;

  reg  [1:0]  pd_st_r;
  reg  [31:0] pd_cnt_r;
  reg         an_seen_r;
  reg  [1:0]  media_nxt;
  wire        cu_lnk_ok;

  assign cu_allow_o = ~(serdes_pref_i & sd_link_i);
  assign cu_lnk_ok  = cu_link_i & cu_allow_o;
  assign link_up_o  = (media_o == `MSEL_MEDIA_COPPER) ? cu_lnk_ok :
                      (media_o == `MSEL_MEDIA_SERDES) ? sd_link_i : 1'b0;

  always @* begin
    media_nxt = `MSEL_MEDIA_NONE;
    if (serdes_pref_i) begin
      if (sd_link_i)
        media_nxt = `MSEL_MEDIA_SERDES;
      else if (cu_link_i)
        media_nxt = `MSEL_MEDIA_COPPER;
    end else begin
      if (cu_link_i || (cu_try_i && sd_link_i && media_o == `MSEL_MEDIA_COPPER))
        media_nxt = `MSEL_MEDIA_COPPER;
      else if (sd_link_i)
        media_nxt = `MSEL_MEDIA_SERDES;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i)
      media_o <= `MSEL_MEDIA_NONE;
    else
      media_o <= media_nxt;
  end

  assign pd_flp_tx_o = (pd_st_r == ST_SRCH);
  assign an_run_o    = an_en_i & (pd_st_r != ST_SRCH);

  always @(posedge clk_i) begin
    if (rst_i) begin
      pd_st_r  <= ST_OFF;
      pd_cnt_r <= 32'h0000_0000;
      pd_res_o <= `MSEL_PD_SEARCH;
      pd_int_o <= 1'b0;
      an_seen_r <= 1'b0;
    end else begin
      // Read clears unless a new event
      if (int_rd_i)
        pd_int_o <= 1'b0;
      case (pd_st_r)
        ST_OFF: begin
          pd_res_o <= `MSEL_PD_SEARCH;
          pd_cnt_r <= 32'h0000_0000;
          if (pd_en_i && an_en_i)
            pd_st_r <= ST_SRCH;
        end
        ST_SRCH: begin
          pd_res_o <= `MSEL_PD_SEARCH;
          pd_cnt_r <= pd_cnt_r + 32'h0000_0001;
          if (!pd_en_i || !an_en_i) begin
            pd_st_r <= ST_OFF;
          end else if (flp_loop_i) begin
            pd_res_o <= `MSEL_PD_FOUND;
            pd_int_o <= 1'b1;
            pd_st_r  <= ST_HOLD;
          end else if (pd_cnt_r >= PD_CYCLES - 1) begin
            pd_res_o  <= `MSEL_PD_NONE;
            an_seen_r <= 1'b0;
            pd_st_r   <= ST_AN;
          end
        end
        ST_HOLD: begin
          if (!pd_en_i)
            pd_st_r <= ST_OFF;
        end
        ST_AN: begin
          pd_cnt_r <= 32'h0000_0000;
          if (link_up_o)
            an_seen_r <= 1'b1;
          if (!pd_en_i) begin
            pd_st_r <= ST_OFF;
          end else if (an_seen_r && !link_up_o) begin
            // Only a link that was up can fail; a quiet cable stays in negotiation
            pd_res_o  <= `MSEL_PD_SEARCH;
            an_seen_r <= 1'b0;
            pd_st_r   <= ST_SRCH;
          end
        end
        default: pd_st_r <= ST_OFF;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      use_rcv_clk_o <= 1'b0;
      freeze_rec_o  <= 1'b0;
    end else if (!ring_swap_i || !link_up_o) begin
      use_rcv_clk_o <= 1'b0;
      freeze_rec_o  <= 1'b0;
    end else if (ring_master_i) begin
      freeze_rec_o  <= 1'b0;
      // Move to recovered clock only after lock, so the swap is smooth
      if (rx_lock_i)
        use_rcv_clk_o <= 1'b1;
    end else begin
      use_rcv_clk_o <= 1'b1;
      freeze_rec_o  <= 1'b1;
    end
  end

endmodule // msel_port

// ==== logic/msel_top.v ====
// Four-port media select, powered-device detection and ring swap with Wishbone registers
`timescale 1ns/1ps
`include "msel_defines.vh"
module msel_top #(
  parameter PD_CYCLES = `MSEL_PD_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        ref_rate_strap_i,
  input  wire [3:0]  cu_link_i,
  input  wire [3:0]  cu_try_i,
  input  wire [3:0]  sd_link_i,
  input  wire [3:0]  flp_loop_i,
  input  wire [3:0]  rx_lock_i,
  output wire [3:0]  cu_allow_o,
  output wire [3:0]  pd_flp_tx_o,
  output wire [3:0]  an_run_o,
  output wire [3:0]  use_rcv_clk_o,
  output wire [3:0]  freeze_rec_o,
  output wire [7:0]  sd_mode_o,
  output reg         ref_125_o,
  output wire        int_o
);

  reg  [3:0]  pref_r;
  reg  [7:0]  mode_r;
  reg  [3:0]  pd_en_r;
  reg  [3:0]  an_en_r;
  reg  [3:0]  swap_r;
  reg  [3:0]  master_r;
  reg         strap_done_r;
  reg  [3:0]  int_rd;
  wire [7:0]  media;
  wire [7:0]  pd_res;
  wire [3:0]  pd_int;
  wire [3:0]  link_up;
  wire        req;
  wire        wr;
  wire [1:0]  port;
  wire [7:0]  idx;
  reg  [31:0] rd_nxt;

  assign req  = cyc_i & stb_i & ~ack_o;
  // Writes land at the edge where the master samples ack, so a held request writes once
  assign wr   = cyc_i & stb_i & ack_o & we_i & sel_i[1] & sel_i[0];
  // Byte address: word index in bits 9:4, port in bits 3:2
  assign port = adr_i[3:2];
  assign idx  = {2'b00, adr_i[9:4]};
  assign sd_mode_o = mode_r;
  assign int_o = |pd_int;

  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_done_r <= 1'b0;
      ref_125_o    <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      ref_125_o    <= ref_rate_strap_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pref_r   <= 4'h0;
      mode_r   <= 8'h00;
      pd_en_r  <= 4'h0;
      an_en_r  <= {4{`MSEL_RST_AN_EN}};
      swap_r   <= 4'h0;
      master_r <= 4'h0;
    end else if (wr) begin
      case (idx)
        `MSEL_IDX_CTRL: begin
          pref_r[port]         <= dat_i[`MSEL_BIT_SERDES_PREF];
          mode_r[port*2 +: 2]  <= dat_i[`MSEL_BIT_MODE_LO +: 2];
        end
        `MSEL_IDX_PD_CTRL:   pd_en_r[port]  <= dat_i[`MSEL_BIT_PD_EN];
        `MSEL_IDX_AN_CTRL:   an_en_r[port]  <= dat_i[`MSEL_BIT_AN_EN];
        `MSEL_IDX_RING_CTRL: begin
          swap_r[port]   <= dat_i[`MSEL_BIT_RING_SWAP];
          master_r[port] <= dat_i[`MSEL_BIT_RING_MASTER];
        end
        default: ;
      endcase
    end
  end

  always @* begin
    rd_nxt = 32'h0000_0000;
    int_rd = 4'h0;
    case (idx)
      `MSEL_IDX_CTRL: begin
        rd_nxt[`MSEL_BIT_SERDES_PREF]    = pref_r[port];
        rd_nxt[`MSEL_BIT_MODE_LO +: 2]   = mode_r[port*2 +: 2];
        rd_nxt[`MSEL_BIT_STRAP]          = ref_125_o;
      end
      `MSEL_IDX_MEDIA_STAT: rd_nxt[`MSEL_BIT_MEDIA_LO +: 2] = media[port*2 +: 2];
      `MSEL_IDX_PD_CTRL: begin
        rd_nxt[`MSEL_BIT_PD_EN]          = pd_en_r[port];
        rd_nxt[`MSEL_BIT_PD_RES_LO +: 2] = pd_res[port*2 +: 2];
      end
      `MSEL_IDX_INT_STAT: begin
        rd_nxt[`MSEL_BIT_PD_INT] = pd_int[port];
        int_rd[port] = req & ~we_i;
      end
      `MSEL_IDX_AN_CTRL:   rd_nxt[`MSEL_BIT_AN_EN] = an_en_r[port];
      `MSEL_IDX_LINK_STAT: rd_nxt[`MSEL_BIT_LINK] = link_up[port];
      `MSEL_IDX_RING_CTRL: begin
        rd_nxt[`MSEL_BIT_RING_SWAP]   = swap_r[port];
        rd_nxt[`MSEL_BIT_RING_MASTER] = master_r[port];
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // One-wait-state answer; unmapped addresses read zero and ignore writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (req && !we_i)
        dat_o <= rd_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MSEL_NPORTS; g = g + 1) begin : g_port
      msel_port #(.PD_CYCLES(PD_CYCLES)) u_port (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .serdes_pref_i (pref_r[g]),
        .pd_en_i       (pd_en_r[g]),
        .an_en_i       (an_en_r[g]),
        .ring_swap_i   (swap_r[g]),
        .ring_master_i (master_r[g]),
        .int_rd_i      (int_rd[g]),
        .cu_link_i     (cu_link_i[g]),
        .cu_try_i      (cu_try_i[g]),
        .sd_link_i     (sd_link_i[g]),
        .flp_loop_i    (flp_loop_i[g]),
        .rx_lock_i     (rx_lock_i[g]),
        .media_o       (media[g*2 +: 2]),
        .cu_allow_o    (cu_allow_o[g]),
        .pd_res_o      (pd_res[g*2 +: 2]),
        .pd_int_o      (pd_int[g]),
        .pd_flp_tx_o   (pd_flp_tx_o[g]),
        .an_run_o      (an_run_o[g]),
        .link_up_o     (link_up[g]),
        .use_rcv_clk_o (use_rcv_clk_o[g]),
        .freeze_rec_o  (freeze_rec_o[g])
      );
    end
  endgenerate

endmodule // msel_top

// ==== tb/msel_chk.sv ====
// Checker for bus timing, media and timing swap outputs of the media select block
`timescale 1ns/1ps
module msel_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire        ack_o,
  input wire [31:0] dat_o,
  input wire        ref_rate_strap_i,
  input wire        ref_125_o,
  input wire [3:0]  flp_loop_i,
  input wire [3:0]  sd_link_i,
  input wire [3:0]  rx_lock_i,
  input wire [3:0]  cu_allow_o,
  input wire [3:0]  pd_flp_tx_o,
  input wire [3:0]  an_run_o,
  input wire [3:0]  use_rcv_clk_o,
  input wire [3:0]  freeze_rec_o,
  input wire [7:0]  sd_mode_o,
  input wire        int_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_pulse:
    assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_dat_hold:
    assert property (!$stable(dat_o) |-> ack_o) else $error("read data moved");
  a_mode_write:
    assert property (!$stable(sd_mode_o) |-> $past(ack_o && we_i)) else $error("mode moved");
  a_strap_copy:
    assert property ($fell(rst_i) |=> ref_125_o == ref_rate_strap_i) else $error("strap");
  a_int_cause:
    assert property ($rose(int_o) |-> $past(|flp_loop_i) || $past(|flp_loop_i, 2)) else $error("int");
  a_cu_block:
    assert property (&(cu_allow_o | sd_link_i)) else $error("copper blocked");
  a_flp_an_excl:
    assert property ((pd_flp_tx_o & an_run_o) == 4'h0) else $error("pulses during autoneg");
  a_freeze_use:
    assert property ((freeze_rec_o & ~use_rcv_clk_o) == 4'h0) else $error("freeze alone");
  a_master_lock:
    assert property ((use_rcv_clk_o & ~$past(use_rcv_clk_o) & ~freeze_rec_o & ~$past(rx_lock_i)) == 4'h0)
      else $error("master swap before lock");
endmodule // msel_chk

bind msel_top msel_chk i_msel_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .ack_o(ack_o), .dat_o(dat_o), .ref_rate_strap_i(ref_rate_strap_i), .ref_125_o(ref_125_o),
  .flp_loop_i(flp_loop_i), .sd_link_i(sd_link_i), .rx_lock_i(rx_lock_i), .cu_allow_o(cu_allow_o),
  .pd_flp_tx_o(pd_flp_tx_o), .an_run_o(an_run_o), .use_rcv_clk_o(use_rcv_clk_o),
  .freeze_rec_o(freeze_rec_o), .sd_mode_o(sd_mode_o), .int_o(int_o));

// ==== tb/msel_peer.sv ====
// Far-side link partner: loops detection pulses back while unpowered, reports timing lock
`timescale 1ns/1ps
module msel_peer (
  input  wire       clk_i,
  input  wire [3:0] flp_tx_i,
  input  wire [3:0] needs_pwr_i,
  input  wire       slow_i,
  input  wire [3:0] lock_en_i,
  output reg  [3:0] flp_loop_o = 4'h0,
  output wire [3:0] rx_lock_o
);
  reg [3:0] loop_d_r = 4'h0;
  always @(posedge clk_i) begin
    loop_d_r   <= flp_tx_i & needs_pwr_i;
    flp_loop_o <= slow_i ? loop_d_r : (flp_tx_i & needs_pwr_i);
  end
  assign rx_lock_o = lock_en_i;
endmodule // msel_peer

// ==== tb/testbench.sv ====
// Self-checking bench for the four-port media select block
`timescale 1ns/1ps
`include "msel_defines.vh"
module testbench;
  localparam PDC = 20;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, strap, ref_125, int_o, slow;
  logic [9:0]  adr_i;
  logic [3:0]  sel_i, cu_link, cu_try, sd_link, flp_loop, rx_lock, needs_pwr, lock_en;
  logic [3:0]  cu_allow, flp_tx, an_run, use_rcv, frz;
  logic [7:0]  sd_mode;
  logic [31:0] dat_i, dat_o, q;
  logic [6:0]  r;
  logic [1:0]  m;
  int          miscompares = 0;
  int          total_checks = 0;
  // Rows: preference, copper linked, copper trying, SerDes linked, media, copper allowed
  logic [6:0]  rows [8] = '{7'h63, 7'h6C, 7'h4C, 7'h41, 7'h0D, 7'h2B, 7'h1B, 7'h01};

  msel_top #(.PD_CYCLES(PDC)) i_msel_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ref_rate_strap_i(strap), .cu_link_i(cu_link), .cu_try_i(cu_try), .sd_link_i(sd_link),
    .flp_loop_i(flp_loop), .rx_lock_i(rx_lock), .cu_allow_o(cu_allow), .pd_flp_tx_o(flp_tx),
    .an_run_o(an_run), .use_rcv_clk_o(use_rcv), .freeze_rec_o(frz), .sd_mode_o(sd_mode),
    .ref_125_o(ref_125), .int_o(int_o));
  msel_peer i_msel_peer (.clk_i(clk_i), .flp_tx_i(flp_tx), .needs_pwr_i(needs_pwr), .slow_i(slow),
    .lock_en_i(lock_en), .flp_loop_o(flp_loop), .rx_lock_o(rx_lock));

  task automatic end_sim;
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string s);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s", $time, s);
    end
  endtask

  task automatic wb(logic w, logic [7:0] idx, logic [1:0] p, logic [3:0] sl, logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, sl};
    adr_i <= {idx[5:0], p, 2'b00};
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    if (ack_o !== 1'b1) begin
      miscompares++;
      $display("FAIL %0t no ack", $time);
      end_sim;
    end
  endtask

  // Long waits only for outputs whose timing depends on the far side
  task automatic wait_for(int s);
    int n;
    n = 0;
    while ((s == 0 ? int_o : (use_rcv[3] & (s == 1 ? frz[3] : ~frz[3]))) !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      $display("FAIL %0t wait %0d", $time, s);
      end_sim;
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, cyc_i, stb_i, we_i, strap, slow} = 6'h23;
    {adr_i, sel_i, dat_i} = '0;
    {cu_link, cu_try, sd_link, needs_pwr, lock_en} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      m = 2'(i % 3);
      wb(1, `MSEL_IDX_CTRL, 0, 4'hF, (32'(r[6]) << 11) | (32'(m) << 8));
      {cu_link[0], cu_try[0], sd_link[0]} <= r[5:3];
      wb(0, `MSEL_IDX_CTRL, 0, 4'hF, 0);
      chk(32'({q[11], q[9:8]}), 32'({r[6], m}), "ctrl");
      chk(32'(sd_mode[1:0]), 32'(m), "mode");
      wb(0, `MSEL_IDX_MEDIA_STAT, 0, 4'hF, 0);
      chk(32'(q[7:6]), 32'(r[2:1]), "media");
      chk(32'(cu_allow[0]), 32'(r[0]), "allow");
    end
    wb(0, `MSEL_IDX_CTRL, 0, 4'hF, 0);
    chk(32'({ref_125, q[4]}), 32'h0000_0003, "strap high");
    needs_pwr <= 4'h2;
    wb(1, `MSEL_IDX_PD_CTRL, 1, 4'hF, 32'h0000_0400);
    wait_for(0);
    needs_pwr <= 4'h0; // host powers the device
    wb(0, `MSEL_IDX_PD_CTRL, 1, 4'hF, 0);
    chk(32'(q[9:8]), 32'(`MSEL_PD_FOUND), "found");
    wb(0, `MSEL_IDX_INT_STAT, 1, 4'hF, 0);
    chk(32'({q[9], int_o}), 32'h0000_0002, "int clear");
    wb(0, `MSEL_IDX_INT_STAT, 1, 4'hF, 0);
    chk(32'(q[9]), 32'h0000_0000, "int stays");
    wb(1, `MSEL_IDX_PD_CTRL, 2, 4'hF, 32'h0000_0400);
    wb(0, `MSEL_IDX_PD_CTRL, 2, 4'hF, 0);
    chk(32'({q[9:8], flp_tx[2], an_run[2]}), 32'h0000_0002, "search");
    repeat (PDC + 4) @(posedge clk_i);
    wb(0, `MSEL_IDX_PD_CTRL, 2, 4'hF, 0);
    chk(32'({q[9:8], flp_tx[2], an_run[2]}), 32'h0000_0009, "timeout");
    cu_link[2] <= 1'b1;
    wb(0, `MSEL_IDX_LINK_STAT, 2, 4'hF, 0);
    chk(32'(q[2]), 32'h0000_0001, "link");
    cu_link[2] <= 1'b0; // link partner drops the copper link
    wb(0, `MSEL_IDX_PD_CTRL, 2, 4'hF, 0);
    chk(32'({q[9:8], flp_tx[2]}), 32'h0000_0001, "back to search");
    cu_link[3] <= 1'b1;
    wb(1, `MSEL_IDX_RING_CTRL, 3, 4'hF, 32'h0000_0001);
    wait_for(1);
    wb(1, `MSEL_IDX_RING_CTRL, 3, 4'hF, 32'h0000_0000);
    wb(1, `MSEL_IDX_RING_CTRL, 3, 4'hF, 32'h0000_0003);
    repeat (4) @(posedge clk_i);
    chk(32'(use_rcv[3]), 32'h0000_0000, "master before lock");
    lock_en <= 4'h8;
    wait_for(2);
    wb(1, 8'h3F, 0, 4'hF, 32'hFFFF_FFFF);
    wb(0, 8'h3F, 0, 4'hF, 0);
    chk(q, 32'h0000_0000, "unmapped");
    wb(1, `MSEL_IDX_CTRL, 0, 4'h2, 32'h0000_0800);
    wb(0, `MSEL_IDX_CTRL, 0, 4'hF, 0);
    chk(32'(q[11]), 32'h0000_0000, "partial write");
    slow <= 1'b0;
    needs_pwr <= 4'h1;
    wb(1, `MSEL_IDX_PD_CTRL, 0, 4'hF, 32'h0000_0400);
    wait_for(0);
    wb(0, `MSEL_IDX_PD_CTRL, 0, 4'hF, 0);
    chk(32'(q[9:8]), 32'(`MSEL_PD_FOUND), "found fast");
    rst_i <= 1'b1;
    strap <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `MSEL_IDX_AN_CTRL, 0, 4'hF, 0);
    chk(32'(q[12]), 32'(`MSEL_RST_AN_EN), "an reset");
    wb(0, `MSEL_IDX_CTRL, 0, 4'hF, 0);
    chk(32'({q[11:8], q[4], ref_125, int_o}), 32'h0000_0000, "reset");
    end_sim;
  end
endmodule // testbench
